// >>> hdl/exec_core_regs.svh
// Purpose: Offsets, field positions, reset values and cycle counts for the execution core.
// Assumes: Register bus addresses are byte addresses of aligned 32-bit words.
// Notes: Definitions only.
// Notes on behaviour
// [RULE1] Absolute non-branch, no index: operand at address field, or at address fetched from it.
// [RULE2] Index modes 11, 01, 10 add x, x+1 or x-1 to the address.
// [RULE3] Absolute branch target is the field or the address fetched from it, never indexed.
// [RULE4] Relative location is offset plus first-byte address plus two, optionally indirect.
// [RULE5] Relative offset is a sign-extended two's complement value.
// [RULE6] add_absolute, opcodes 8C-8F, 4 cycles, adds memory byte into r.
// [RULE7] Indexed absolute add or AND selects index by low bits; result goes to register zero.
// [RULE8] Adds include the carry only when the carry chain enable bit is 1.
// [RULE9] Adds update carry, condition code, half-byte carry and overflow; CC 01/00/10.
// [RULE10] add_immediate, opcodes 84-87, 2 cycles, adds second byte into r.
// [RULE11] Relative add, opcodes 88-8B, 3 cycles, adds relative operand into r.
// [RULE12] add_into_reg0, opcodes 80-83, 2 cycles, adds r into register zero.
// [RULE13] and_absolute, opcodes 4C-4F, 4 cycles, ANDs memory byte into r.
// [RULE14] and_immediate, opcodes 44-47, 2 cycles, ANDs second byte into r.
// [RULE15] and_relative, opcodes 48-4B, 3 cycles, ANDs relative operand into r.
// [RULE16] and_into_reg0, opcodes 41-43, ANDs r into register zero; 01000000 is halt.
// [RULE17] AND changes only the condition code, same encoding as adds.
// [RULE18] branch_false_absolute, 9C-9E, 3 cycles, branches when v differs from CC.
// [RULE19] branch_false_relative, 98-9A, 3 cycles, branches when v differs from CC.
// [RULE20] Code point with v equal 3 is the indexed branch op, not a conditional branch.
// [RULE21] Branch-false instructions leave all status bits unchanged.
// [RULE22] Indirection adds 2 cycles; for branches only when taken.
// [RULE23] Indexed address arithmetic wraps inside the current page.
// [RULE24] Indirect address is two bytes, right-justified 15 bits, top bit ignored, one level.
// [RULE25] Overflow on equal-sign operands giving opposite sign; half-byte carry is bit-3 carry.
`ifndef EXEC_CORE_REGS_SVH
`define EXEC_CORE_REGS_SVH
`define OFS_REG0 8'h00
`define OFS_REG1 8'h04
`define OFS_REG2 8'h08
`define OFS_REG3 8'h0c
`define OFS_PSW 8'h10
`define OFS_IPTR 8'h14
`define OFS_CTRL 8'h18
`define OFS_STAT 8'h1c
`define CTRL_STEP_BIT 0
`define CTRL_RUN_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_HALT_BIT 1
`define STAT_BADOP_BIT 2
`define STAT_XBR_BIT 3
`define PSW_RESET 8'h00
`define IPTR_RESET 15'h0000
`define HALT_OPCODE 8'h40
`define CLKS_PER_CYCLE 5'h03
`define CYC_ABS 3'h4
`define CYC_REL 3'h3
`define CYC_SHORT 3'h2
`define CYC_BRANCH 3'h3
`define CYC_INDIRECT 3'h2
`endif

// >>> hdl/exec_core_pkg.sv
// Purpose: Types shared by the execution core.
// Assumes: Nothing beyond the constants header.
// Notes: Status word layout follows the processor's lower status byte.
package exec_core_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_ADDR, ST_IND, ST_OPER, ST_EXEC, ST_PAD} exec_state_t;

    typedef struct packed {
        logic [1:0] condition_code;
        logic half_byte_carry;
        logic bank_sel;
        logic carry_chain_enable;
        logic overflow_flag;
        logic compare_mode;
        logic carry;
    } program_status_word_t;

    typedef struct packed {
        logic rd;
        logic [14:0] addr;
    } mem_req_t;
endpackage

// >>> hdl/exec_core.sv
// Purpose: Executes add, AND and branch-on-condition-false instructions with address generation.
// Assumes: Memory answers a read with data in the same cycle that the request is high.
// Notes: One processor cycle is three clocks; each instruction is padded to its cycle count.
`timescale 1ns/10ps
`include "exec_core_regs.svh"
module exec_core
    import exec_core_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    output logic busy_o
);
    exec_state_t state_q;
    logic [7:0] regs_q [0:3];
    program_status_word_t psw_q;
    logic [14:0] iptr_q;
    logic [7:0] ibuf_q [0:2];
    logic [1:0] byte_n_q;
    logic [1:0] len_q;
    logic ind_n_q;
    logic [6:0] ind_hi_q;
    logic [14:0] ind_addr_q;
    logic [7:0] opnd_q;
    logic [4:0] clk_cnt_q;
    mem_req_t mem_req_q;
    logic busy_q;
    logic run_q;
    logic halted_q;
    logic badop_q;
    logic xbr_q;
    logic [31:0] rdata_q;

    function automatic logic [1:0] len_of(input logic [7:0] b);
        case (b[3:2])
            2'b00: len_of = 2'h1;
            2'b11: len_of = 2'h3;
            default: len_of = 2'h2;
        endcase
    endfunction

    // Decode of the captured instruction.
    logic [7:0] b0, b1, b2;
    logic [1:0] rsel, mode, page;
    logic is_add, is_and, is_bcf, ind_bit, indexed, taken, do_ind, need_oper;
    logic [12:0] rel_base;
    logic [14:0] rel_ea, abs_nb_ea, abs_br_ea, pre_ea, base_ea, fin_ea, seq_iptr, rd_addr;
    logic [7:0] xval, acc, src, res;
    logic [8:0] sum9;
    logic [4:0] nib;
    logic cin;
    logic [1:0] res_cc;
    logic [2:0] cyc;
    logic [4:0] tgt;
    logic [1:0] dst;
    logic start, exec, bad_first, halt_first, xbr_first, first_cap;

    assign b0 = ibuf_q[0];
    assign b1 = ibuf_q[1];
    assign b2 = ibuf_q[2];
    assign rsel = b0[1:0];
    assign mode = b0[3:2];
    assign page = iptr_q[14:13];
    assign is_add = b0[7:4] == 4'h8;
    assign is_and = (b0[7:4] == 4'h4) && (b0 != `HALT_OPCODE); // [RULE16]
    assign is_bcf = b0[7:4] == 4'h9;
    assign ind_bit = mode[1] && b1[7];
    assign indexed = !is_bcf && (mode == 2'b11) && (b1[6:5] != 2'b00); // [RULE3]

    // Relative base is the address after a two-byte instruction.
    assign rel_base = iptr_q[12:0] + 13'h0002; // [RULE4]
    assign rel_ea = {page, rel_base + {{6{b1[6]}}, b1[6:0]}}; // [RULE5]
    assign abs_nb_ea = {page, b1[4:0], b2}; // [RULE1]
    assign abs_br_ea = {b1[6:0], b2}; // [RULE3]
    assign pre_ea = (mode == 2'b10) ? rel_ea : (is_bcf ? abs_br_ea : abs_nb_ea);
    assign base_ea = ind_bit ? ind_addr_q : pre_ea; // [RULE1] [RULE3] [RULE4]

    always_comb begin
        case (b1[6:5])
            2'b01: xval = regs_q[rsel] + 8'h01; // [RULE2]
            2'b10: xval = regs_q[rsel] - 8'h01; // [RULE2]
            default: xval = regs_q[rsel]; // [RULE2]
        endcase
    end

    // Index addition stays inside the page of the base address.
    assign fin_ea = indexed ? {base_ea[14:13], base_ea[12:0] + {5'h00, xval}} : base_ea; // [RULE23]
    assign taken = is_bcf && (b0[1:0] != psw_q.condition_code); // [RULE18] [RULE19]
    assign do_ind = ind_bit && (!is_bcf || taken); // [RULE22]
    assign need_oper = (is_add || is_and) && mode[1];
    assign seq_iptr = {page, iptr_q[12:0] + {11'h000, len_q}};

    always_comb begin
        case (mode)
            2'b00: src = regs_q[rsel]; // [RULE12] [RULE16]
            2'b01: src = b1; // [RULE10] [RULE14]
            default: src = opnd_q; // [RULE6] [RULE11] [RULE13] [RULE15]
        endcase
    end

    assign dst = ((mode == 2'b00) || indexed) ? 2'b00 : rsel; // [RULE7] [RULE12]
    assign acc = regs_q[dst];
    assign cin = psw_q.carry_chain_enable & psw_q.carry; // [RULE8]
    assign sum9 = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
    assign nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    assign res = is_add ? sum9[7:0] : (acc & src); // [RULE17]
    assign res_cc = (res == 8'h00) ? 2'b00 : (res[7] ? 2'b10 : 2'b01); // [RULE9] [RULE17]

    always_comb begin
        if (is_bcf) begin
            cyc = `CYC_BRANCH;
        end else begin
            case (mode)
                2'b11: cyc = `CYC_ABS;
                2'b10: cyc = `CYC_REL;
                default: cyc = `CYC_SHORT;
            endcase
        end
        if (do_ind) begin
            cyc = cyc + `CYC_INDIRECT; // [RULE22]
        end
    end
    assign tgt = {2'b00, cyc} * `CLKS_PER_CYCLE;

    always_comb begin
        case (state_q)
            ST_FETCH: rd_addr = {page, iptr_q[12:0] + {11'h000, byte_n_q}};
            ST_IND: rd_addr = pre_ea + {14'h0000, ind_n_q}; // [RULE24]
            default: rd_addr = fin_ea;
        endcase
    end

    assign start = ce_i && (state_q == ST_IDLE)
                   && ((wr_i && (addr_i == `OFS_CTRL) && wdata_i[`CTRL_STEP_BIT]) || run_q);
    assign exec = ce_i && (state_q == ST_EXEC);
    assign first_cap = ce_i && (state_q == ST_FETCH) && mem_req_q.rd && (byte_n_q == 2'h0);
    assign halt_first = first_cap && (mem_rdata_i == `HALT_OPCODE); // [RULE16]
    assign xbr_first = first_cap && (mem_rdata_i[7:4] == 4'h9) && (mem_rdata_i[1:0] == 2'b11); // [RULE20]
    assign bad_first = first_cap && !halt_first && !xbr_first
                       && !((mem_rdata_i[7:4] == 4'h8) || (mem_rdata_i[7:4] == 4'h4)
                       || ((mem_rdata_i[7:4] == 4'h9) && mem_rdata_i[3]));

    // Sequencer: reads are issued one at a time, data captured the following cycle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            byte_n_q <= 2'h0;
            len_q <= 2'h1;
            ind_n_q <= 1'b0;
            ind_hi_q <= 7'h00;
            ind_addr_q <= 15'h0000;
            opnd_q <= 8'h00;
            clk_cnt_q <= 5'h00;
            mem_req_q <= '0;
            busy_q <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                ibuf_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (state_q != ST_IDLE) begin
                clk_cnt_q <= clk_cnt_q + 5'h01;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_FETCH;
                        busy_q <= 1'b1;
                        byte_n_q <= 2'h0;
                        ind_n_q <= 1'b0;
                        clk_cnt_q <= 5'h00;
                    end
                end
                ST_FETCH: begin
                    if (!mem_req_q.rd) begin
                        mem_req_q <= '{rd: 1'b1, addr: rd_addr};
                    end else begin
                        mem_req_q.rd <= 1'b0;
                        ibuf_q[byte_n_q] <= mem_rdata_i;
                        byte_n_q <= byte_n_q + 2'h1;
                        if (byte_n_q == 2'h0) begin
                            len_q <= len_of(mem_rdata_i);
                        end
                        if (halt_first || xbr_first || bad_first) begin
                            // Unhandled opcodes stop here so software can take over.
                            state_q <= ST_IDLE;
                            busy_q <= 1'b0;
                        end else if ((byte_n_q + 2'h1) == ((byte_n_q == 2'h0) ? len_of(mem_rdata_i) : len_q)) begin
                            // Immediate forms need no address work, so they skip it to fit in two cycles.
                            state_q <= ((byte_n_q == 2'h1) && (mode == 2'b01)) ? ST_EXEC : ST_ADDR; // [RULE10] [RULE14]
                        end
                    end
                end
                ST_ADDR: begin
                    state_q <= do_ind ? ST_IND : (need_oper ? ST_OPER : ST_EXEC);
                end
                ST_IND: begin
                    if (!mem_req_q.rd) begin
                        mem_req_q <= '{rd: 1'b1, addr: rd_addr};
                    end else begin
                        mem_req_q.rd <= 1'b0;
                        ind_n_q <= 1'b1;
                        if (!ind_n_q) begin
                            ind_hi_q <= mem_rdata_i[6:0]; // [RULE24]
                        end else begin
                            ind_addr_q <= {ind_hi_q, mem_rdata_i}; // [RULE24]
                            state_q <= need_oper ? ST_OPER : ST_EXEC;
                        end
                    end
                end
                ST_OPER: begin
                    if (!mem_req_q.rd) begin
                        mem_req_q <= '{rd: 1'b1, addr: rd_addr};
                    end else begin
                        mem_req_q.rd <= 1'b0;
                        opnd_q <= mem_rdata_i;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_PAD;
                end
                ST_PAD: begin
                    if (clk_cnt_q >= tgt - 5'h01) begin // [RULE6] [RULE10] [RULE11] [RULE13] [RULE18]
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // General registers: execution results take priority over bus writes.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 4; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (wr_i && (addr_i[7:4] == 4'h0) && (addr_i[1:0] == 2'b00)) begin
                regs_q[addr_i[3:2]] <= wdata_i[7:0];
            end
            if (exec && (is_add || is_and)) begin
                if (indexed && (b1[6:5] != 2'b11)) begin
                    regs_q[rsel] <= xval; // [RULE2]
                end
                regs_q[dst] <= res; // [RULE6] [RULE7] [RULE12] [RULE13] [RULE16]
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            psw_q <= `PSW_RESET;
        end else if (ce_i) begin
            if (wr_i && (addr_i == `OFS_PSW)) begin
                psw_q <= wdata_i[7:0];
            end
            if (exec && is_add) begin
                psw_q.carry <= sum9[8]; // [RULE9]
                psw_q.half_byte_carry <= nib[4]; // [RULE25]
                psw_q.overflow_flag <= (acc[7] == src[7]) && (res[7] != acc[7]); // [RULE25]
                psw_q.condition_code <= res_cc; // [RULE9]
            end else if (exec && is_and) begin
                psw_q.condition_code <= res_cc; // [RULE17]
            end
            // Branch-false execution writes nothing here. [RULE21]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            iptr_q <= `IPTR_RESET;
        end else if (ce_i) begin
            if (wr_i && (addr_i == `OFS_IPTR)) begin
                iptr_q <= wdata_i[14:0];
            end
            if (exec) begin
                iptr_q <= taken ? fin_ea : seq_iptr; // [RULE18] [RULE19]
            end
        end
    end

    // Control and sticky status; a hardware set wins over a clear in the same cycle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_q <= 1'b0;
            halted_q <= 1'b0;
            badop_q <= 1'b0;
            xbr_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && (addr_i == `OFS_CTRL)) begin
                run_q <= wdata_i[`CTRL_RUN_BIT];
            end
            if (wr_i && (addr_i == `OFS_STAT)) begin
                halted_q <= halted_q & ~wdata_i[`STAT_HALT_BIT];
                badop_q <= badop_q & ~wdata_i[`STAT_BADOP_BIT];
                xbr_q <= xbr_q & ~wdata_i[`STAT_XBR_BIT];
            end
            if (halt_first || bad_first || xbr_first) begin
                run_q <= 1'b0;
            end
            if (halt_first) begin
                halted_q <= 1'b1; // [RULE16]
            end
            if (bad_first) begin
                badop_q <= 1'b1;
            end
            if (xbr_first) begin
                xbr_q <= 1'b1; // [RULE20]
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h00000000;
        end else if (ce_i) begin
            rdata_q <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `OFS_REG0, `OFS_REG1, `OFS_REG2, `OFS_REG3: rdata_q <= {24'h000000, regs_q[addr_i[3:2]]};
                    `OFS_PSW: rdata_q <= {24'h000000, psw_q};
                    `OFS_IPTR: rdata_q <= {17'h00000, iptr_q};
                    `OFS_CTRL: rdata_q <= {30'h00000000, run_q, 1'b0};
                    `OFS_STAT: rdata_q <= {28'h0000000, xbr_q, badop_q, halted_q, busy_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;
    assign mem_req_o = mem_req_q;
    assign busy_o = busy_q;
endmodule // exec_core

// >>> verif/exec_core_props.sv
// Purpose: Port-level timing checks for the execution core.
// Assumes: ce_i stays high while an instruction runs.
// Notes: The opcode is taken from the answer to the first fetch of each instruction.
`timescale 1ns/10ps
module exec_core_props
    import exec_core_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [5:0] clk_cnt_q;
    logic [3:0] rd_cnt_q;
    logic [7:0] op_q;
    logic got_q;
    logic short_op, rel_op, abs_op, br_op, imm_op, reg_op;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_cnt_q <= 6'h00;
            rd_cnt_q <= 4'h0;
        end else if (ce_i) begin
            clk_cnt_q <= busy_o ? clk_cnt_q + 6'h01 : 6'h00;
            rd_cnt_q <= busy_o ? rd_cnt_q + {3'h0, mem_req_o.rd} : 4'h0;
        end
    end
    // Only the first answer is kept, because later answers carry operands and pointers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_q <= 8'h00;
            got_q <= 1'b0;
        end else if (!busy_o) begin
            got_q <= 1'b0;
        end else if (rd_cnt_q == 4'h0 && mem_req_o.rd && !got_q) begin
            op_q <= mem_rdata_i;
            got_q <= 1'b1;
        end
    end
    assign imm_op = op_q[7:2] == 6'h21 || op_q[7:2] == 6'h11;
    assign reg_op = op_q[7:2] == 6'h20 || op_q inside {8'h41, 8'h42, 8'h43};
    assign short_op = imm_op || reg_op;
    assign rel_op = op_q[7:2] == 6'h22 || op_q[7:2] == 6'h12;
    assign abs_op = op_q[7:2] == 6'h23 || op_q[7:2] == 6'h13;
    assign br_op = op_q[7:3] == 5'h13 && op_q[1:0] != 2'h3;
    AST_RD_IN_BUSY: assert property (mem_req_o.rd |-> busy_o)
        else $error("memory read outside an instruction");
    AST_RD_SPACED: assert property (mem_req_o.rd |=> !mem_req_o.rd)
        else $error("memory reads back to back");
    AST_FETCH_START: assert property ($rose(busy_o) |=> mem_req_o.rd)
        else $error("instruction did not start with a fetch");
    AST_FETCH_NEXT: assert property (($rose(busy_o) ##3 mem_req_o.rd) |->
        mem_req_o.addr[12:0] == $past(mem_req_o.addr[12:0], 2) + 13'h0001)
        else $error("second fetch not at the next byte");
    AST_SHORT_TIME: assert property ($fell(busy_o) && short_op |-> clk_cnt_q == 6'h06)
        else $error("short instruction time wrong");
    AST_REL_TIME: assert property ($fell(busy_o) && rel_op |-> clk_cnt_q inside {6'h09, 6'h0f})
        else $error("relative instruction time wrong");
    AST_ABS_TIME: assert property ($fell(busy_o) && abs_op |-> clk_cnt_q inside {6'h0c, 6'h12})
        else $error("absolute instruction time wrong");
    AST_BR_TIME: assert property ($fell(busy_o) && br_op |-> clk_cnt_q inside {6'h09, 6'h0f})
        else $error("branch time wrong");
    AST_REG_READS: assert property ($fell(busy_o) && reg_op |-> rd_cnt_q == 4'h1)
        else $error("register form read count wrong");
    AST_IMM_READS: assert property ($fell(busy_o) && imm_op |-> rd_cnt_q == 4'h2)
        else $error("immediate form read count wrong");
endmodule // exec_core_props
bind exec_core exec_core_props i_props (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .mem_req_o(mem_req_o),
    .mem_rdata_i(mem_rdata_i),
    .busy_o(busy_o)
);

// >>> verif/exec_mem_model.sv
// Purpose: Memory answering the execution core's reads.
// Assumes: Data stands while the request is high; the core takes it at the next edge.
// Notes: Outside a request the data shows the inverse of its last value, so a late capture shows up.
`timescale 1ns/10ps
module exec_mem_model
    import exec_core_pkg::*;
(
    input wire logic clk_i,
    input wire mem_req_t req_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:32767];
    logic [7:0] last_q = 8'h00;
    always @(posedge clk_i) begin
        last_q <= rdata_o;
    end
    assign rdata_o = req_i.rd ? mem[req_i.addr] : ~last_q;
endmodule // exec_mem_model

// >>> verif/ea_add_and_branch_false_exec_test.sv
// Purpose: Runs single instructions and checks registers, status and pointer.
// Assumes: Step mode only; ce_i held high.
// Notes: Each case presets R0-R3 and the status word over the register port.
`timescale 1ns/10ps
`include "exec_core_regs.svh"
module ea_add_and_branch_false_exec_test
    import exec_core_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    mem_req_t mem_req_o;
    logic [7:0] mem_rdata_i;
    logic busy_o;
    int miscompares = 0;
    int cmp_count = 0;
    always #5 clk_i = ~clk_i;
    exec_core i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i),
        .busy_o(busy_o));
    exec_mem_model i_mem (.clk_i(clk_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is sampled just after that edge.
    task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, exp, rdata_o);
    endtask
    task automatic run_case(input logic [14:0] ip, input logic [23:0] code, input logic [39:0] pre,
        input logic [1:0] r, input logic [23:0] exp, input logic [14:0] exp_ip);
        int n;
        for (n = 0; n < 3; n++) begin
            i_mem.mem[ip + 15'(n)] = code[8*n +: 8];
        end
        for (n = 0; n < 5; n++) begin
            reg_wr(`OFS_REG0 + 8'(4 * n), {24'h0, pre[8*n +: 8]});
        end
        reg_wr(`OFS_IPTR, {17'h0, ip});
        reg_wr(`OFS_CTRL, 32'h1);
        #1;
        n = 0;
        while (busy_o !== 1'b0 && n < 50) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 0 || n == 50) begin
            check("busy span", 32'h1, 32'h0);
            give_verdict();
        end
        reg_chk("result", `OFS_REG0 + {4'h0, r, 2'h0}, {24'h0, exp[7:0]});
        reg_chk("status word", `OFS_PSW, {24'h0, exp[15:8]});
        reg_chk("pointer", `OFS_IPTR, {17'h0, exp_ip});
        reg_chk("stat", `OFS_STAT, {24'h0, exp[23:16]});
        reg_wr(`OFS_STAT, 32'he);
        $display("Test at %h done", ip);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            reg_chk("reset value", 8'(4 * a), 32'h0);
        end
        $display("Test reset values done");
        i_mem.mem[15'h0000] = 8'h11;
        i_mem.mem[15'h01fe] = 8'h05;
        i_mem.mem[15'h0304] = 8'h85;
        i_mem.mem[15'h0305] = 8'h10;
        i_mem.mem[15'h0510] = 8'h0f;
        i_mem.mem[15'h0600] = 8'h07;
        i_mem.mem[15'h0601] = 8'h00;
        i_mem.mem[15'h0700] = 8'haa;
        i_mem.mem[15'h0912] = 8'h0a;
        i_mem.mem[15'h0913] = 8'h00;
        i_mem.mem[15'h010f] = 8'h3c;
        run_case(15'h100, 24'h007f85, 40'h0900000100, 2'd1, 24'h00ac81, 15'h102);
        run_case(15'h110, 24'h000184, 40'h01000000ff, 2'd0, 24'h002100, 15'h112);
        run_case(15'h120, 24'h000082, 40'h0000220010, 2'd0, 24'h004032, 15'h121);
        reg_chk("source kept", `OFS_REG2, 32'h22);
        run_case(15'h130, 24'h000043, 40'h0d3c0000f0, 2'd0, 24'h004d30, 15'h131);
        run_case(15'h140, 24'h008046, 40'h2500ff0000, 2'd2, 24'h00a580, 15'h142);
        run_case(15'h200, 24'h007c89, 40'h0000000300, 2'd1, 24'h004008, 15'h202);
        run_case(15'h300, 24'h008248, 40'h000000003c, 2'd0, 24'h00400c, 15'h302);
        run_case(15'h400, 24'hfe3f8d, 40'h0000000122, 2'd0, 24'h004033, 15'h403);
        reg_chk("index bumped", `OFS_REG1, 32'h2);
        run_case(15'h500, 24'h00864e, 40'h0000ff0000, 2'd2, 24'h0080aa, 15'h503);
        run_case(15'hd00, 24'h10404d, 40'h00000000f0, 2'd0, 24'h004030, 15'hd03);
        reg_chk("index dropped", `OFS_REG1, 32'hff);
        run_case(15'h780, 24'h50079d, 40'h8000000000, 2'd0, 24'h008000, 15'h750);
        run_case(15'h800, 24'h50079e, 40'h8000000000, 2'd0, 24'h008000, 15'h803);
        run_case(15'h900, 24'h009098, 40'h4000000000, 2'd0, 24'h004000, 15'ha00);
        run_case(15'ha00, 24'h009099, 40'h4000000000, 2'd0, 24'h004000, 15'ha02);
        run_case(15'hb00, 24'h00109b, 40'h4000000000, 2'd0, 24'h084000, 15'hb00);
        run_case(15'hc00, 24'h000040, 40'h400000005a, 2'd0, 24'h02405a, 15'hc00);
        give_verdict();
    end
endmodule // ea_add_and_branch_false_exec_test
